/* File: verilog/periodic_wakeup_unit.sv */
// stop-mode periodic wakeup unit with shared keyboard request flag
// Operation
// - periodic wakeup requests while stopped
// - starts automatically on stop entry when enabled
// - counters restart from zero each stop entry
// - idle in run mode
// - idle in wait mode
// - clock keep bit selects counter clock source
// - overflow latches and forwards wakeup request
// - period select one short, zero long
// - latch captures only when request and enabled
// - latch readable as port a bit six
// - acknowledge write or reset clears latch
// - latch readback ignores enable bit
// - serviced via keyboard vector only when enabled
// - short 512, long 16384 counter clocks
// - acknowledge write-only, reads zero
// - pending flag shows keyboard or wakeup pending
module periodic_wakeup_unit
(
  // clock, reset, clock enable
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // power mode
  input  wire logic       stop_mode,
  input  wire logic       wait_mode,
  // counter clock ticks, one cycle each
  input  wire logic       rc_osc_tick,
  input  wire logic       bus_x2_tick,
  // configuration bits
  input  wire logic       wakeup_irq_enable,
  input  wire logic       clock_keep_in_stop,
  input  wire logic       period_select,
  input  wire logic       keyboard_irq_mask,
  // keyboard side
  input  wire logic       keyboard_request,
  input  wire logic       keyboard_acknowledge,
  // status and requests
  output logic            wakeup_latch,
  output logic [7:0]      port_a_read,
  output logic            ack_read,
  output logic            keyboard_pending_flag,
  output logic            wakeup_request,
  output logic            irq_to_cpu
);
  logic [wakeup_pkg::CNT_W-1:0] count;
  logic                         stop_prev;
  logic                         running;
  logic                         tick;
  logic                         at_end;

  function automatic logic [13:0] end_count(input logic short_sel);
    end_count = short_sel ? (wakeup_pkg::SHORT_COUNT - 14'h0001) : wakeup_pkg::LONG_COUNT;
  endfunction : end_count

  // run only in stop with enable set; wait mode keeps it idle
  // with the enable clear nothing could latch, so the counter stays parked at zero
  assign running = stop_mode && !wait_mode && wakeup_irq_enable;
  // a tick only counts on an enabled edge, so a frozen unit raises no request either
  assign tick    = clk_en && (clock_keep_in_stop ? bus_x2_tick : rc_osc_tick);
  assign at_end  = (count == end_count(period_select));

  // stop-entry edge tracking
  // reset leaves this low, so a reset taken in stop still counts as a fresh entry
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      stop_prev <= 1'b0;
    else if (clk_en)
      stop_prev <= stop_mode;
  end

  // interval counter, cleared on stop entry and outside stop
  // clearing on the way out too means no stale count survives into the next stop
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      count <= wakeup_pkg::CNT_RESET;
    else if (clk_en)
    begin
      if (!running || (stop_mode && !stop_prev))
        count <= wakeup_pkg::CNT_RESET;
      else if (tick)
        count <= at_end ? wakeup_pkg::CNT_RESET : count + 14'h0001;
    end
  end

  // overflow pulse to latch
  assign wakeup_request = running && tick && at_end && stop_prev;

  // wakeup latch: set wins over acknowledge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wakeup_latch <= wakeup_pkg::LATCH_RESET;
    else if (clk_en)
    begin
      if (wakeup_request && wakeup_irq_enable)
        wakeup_latch <= 1'b1;
      else if (keyboard_acknowledge)
        wakeup_latch <= 1'b0;
    end
  end

  // shared keyboard pending flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      keyboard_pending_flag <= wakeup_pkg::FLAG_RESET;
    else if (clk_en)
    begin
      if (keyboard_request || (wakeup_request && wakeup_irq_enable))
        keyboard_pending_flag <= 1'b1;
      else if (keyboard_acknowledge)
        keyboard_pending_flag <= 1'b0;
    end
  end

  // port a readback: only the latch position carries a value, the rest read zero
  generate
    for (genvar b = 0; b < 8; b++)
    begin : g_port_a
      if (b == wakeup_pkg::LATCH_BIT)
      begin : g_latch
        assign port_a_read[b] = wakeup_latch;
      end
      else
      begin : g_empty
        assign port_a_read[b] = 1'b0;
      end
    end
  endgenerate

  // acknowledge reads back zero; a disabled wakeup never reaches the cpu
  assign ack_read    = 1'b0;
  assign irq_to_cpu  = keyboard_pending_flag && !keyboard_irq_mask
                       && (wakeup_irq_enable || !wakeup_latch || keyboard_request);

  // checks: run and wait modes keep the unit quiet
  idle_in_run_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stop_mode |-> !wakeup_request)
    else $error("request outside stop");
  idle_in_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    wait_mode |-> !wakeup_request)
    else $error("request in wait");
  count_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !stop_mode |=> count == wakeup_pkg::CNT_RESET)
    else $error("counter moves in run");
  wait_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wait_mode |=> count == wakeup_pkg::CNT_RESET)
    else $error("counter moves in wait");

  // checks: counting, clock source and period length
  restart_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && stop_mode && !stop_prev |=> count == 14'h0000)
    else $error("no restart");
  count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && running && stop_prev && tick && !at_end |=> count == $past(count) + 14'h0001)
    else $error("counter missed a tick");
  wrap_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    wakeup_request |=> count == wakeup_pkg::CNT_RESET)
    else $error("no wrap after request");
  rc_source_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && running && stop_prev && !clock_keep_in_stop && !rc_osc_tick |=> $stable(count))
    else $error("counter moved without rc tick");
  bus_source_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && running && stop_prev && clock_keep_in_stop && !bus_x2_tick |=> $stable(count))
    else $error("counter moved without bus tick");
  short_period_a: assert property (@(posedge clock) disable iff (!rst_n)
    wakeup_request && period_select |-> count == 14'h01ff)
    else $error("short period");
  long_period_a: assert property (@(posedge clock) disable iff (!rst_n)
    wakeup_request && !period_select |-> count == 14'h3fff)
    else $error("long period");

  // checks: wakeup latch and its readback
  latch_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wakeup_request && wakeup_irq_enable |=> wakeup_latch)
    else $error("latch missed");
  latch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(wakeup_irq_enable) && !$past(wakeup_latch) |-> !wakeup_latch)
    else $error("latch no enable");
  latch_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && keyboard_acknowledge && !wakeup_request |=> !wakeup_latch)
    else $error("ack failed");
  reset_clear_a: assert property (@(posedge clock)
    !rst_n |=> !wakeup_latch && !keyboard_pending_flag)
    else $error("reset left a request");
  porta_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    port_a_read[6] == wakeup_latch && port_a_read[7] == 1'b0 && port_a_read[5:0] == 6'h00)
    else $error("port a bad");

  // checks: shared keyboard flag and acknowledge
  ack_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    ack_read == 1'b0)
    else $error("ack reads one");
  flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && keyboard_request |=> keyboard_pending_flag)
    else $error("flag missed");
  flag_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wakeup_request |=> keyboard_pending_flag)
    else $error("flag missed wakeup");
  flag_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && keyboard_acknowledge && !keyboard_request && !wakeup_request
    |=> !keyboard_pending_flag)
    else $error("flag not cleared");

  // checks: interrupt towards the cpu
  irq_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
    keyboard_irq_mask |-> !irq_to_cpu)
    else $error("masked irq");
  irq_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !wakeup_irq_enable && wakeup_latch && !keyboard_request |-> !irq_to_cpu)
    else $error("disabled wakeup reached cpu");
  irq_on_a: assert property (@(posedge clock) disable iff (!rst_n)
    keyboard_pending_flag && !keyboard_irq_mask && wakeup_irq_enable |-> irq_to_cpu)
    else $error("enabled request not raised");

  // checks: a low clock enable freezes every register
  freeze_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(count) && $stable(stop_prev) && $stable(wakeup_latch)
    && $stable(keyboard_pending_flag))
    else $error("state moved while frozen");

  // main scenarios
  wake_cov: cover property (@(posedge clock) wakeup_request && wakeup_irq_enable);
  ack_cov: cover property (@(posedge clock) wakeup_latch ##1 keyboard_acknowledge ##1 !wakeup_latch);
  irq_cov: cover property (@(posedge clock) irq_to_cpu && wakeup_latch);
  long_cov: cover property (@(posedge clock) wakeup_request && !period_select);
  bus_cov: cover property (@(posedge clock) wakeup_request && clock_keep_in_stop);
endmodule : periodic_wakeup_unit

/* File: verilog/wakeup_pkg.sv */
// constants for the stop-mode periodic wakeup unit
package wakeup_pkg;
  localparam int unsigned CNT_W       = 14;
  localparam logic [13:0] SHORT_COUNT = 14'h0200; // 512 counter clocks
  localparam logic [13:0] LONG_COUNT  = 14'h3fff; // 16,384 counter clocks, terminal value
  localparam logic [13:0] CNT_RESET   = 14'h0000;
  localparam int unsigned LATCH_BIT   = 6;         // position in port a data register
  localparam logic        LATCH_RESET = 1'b0;
  localparam logic        FLAG_RESET  = 1'b0;
endpackage : wakeup_pkg

/* File: test/cpu_ack_model.sv */
// interrupt handler model that acknowledges the shared keyboard request
module cpu_ack_model #(parameter int unsigned LATENCY = 3)
(
  // clock and handler enable
  input  wire logic clock,
  input  wire logic serve,
  // request from the unit, acknowledge back to it
  input  wire logic irq_to_cpu,
  output logic      keyboard_acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_count = 0;
  // count request cycles, then pulse the acknowledge write for one cycle
  always @(negedge clock)
  begin
    keyboard_acknowledge <= (wait_count == LATENCY);
    wait_count <= (serve && irq_to_cpu === 1'b1 && !keyboard_acknowledge) ? wait_count + 1 : 0;
  end
endmodule : cpu_ack_model

/* File: test/periodic_wakeup_unit_tb.sv */
// bench for the stop-mode periodic wakeup unit
module periodic_wakeup_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, stop_mode = 0, wait_mode = 0, rc_osc_tick = 0, bus_x2_tick = 0;
  logic wakeup_irq_enable = 0, clock_keep_in_stop = 0, period_select = 1, keyboard_irq_mask = 1;
  logic keyboard_request = 0, serve = 0, keyboard_acknowledge, wakeup_latch, ack_read;
  logic keyboard_pending_flag, wakeup_request, irq_to_cpu, clk_en = 1;
  logic [7:0] port_a_read;
  int n_mismatch = 0, tests_run = 0, n_req = 0;
  periodic_wakeup_unit periodic_wakeup_unit_i (.clock, .rst_n, .clk_en, .stop_mode,
    .wait_mode, .rc_osc_tick, .bus_x2_tick, .wakeup_irq_enable, .clock_keep_in_stop,
    .period_select, .keyboard_irq_mask, .keyboard_request, .keyboard_acknowledge, .wakeup_latch,
    .port_a_read, .ack_read, .keyboard_pending_flag, .wakeup_request, .irq_to_cpu);
  cpu_ack_model cpu_ack_model_i (.clock, .serve, .irq_to_cpu, .keyboard_acknowledge);
  initial forever #20 clock = ~clock;
  task chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // back-to-back counter clock ticks, counting wakeup pulses seen mid-cycle
  task ticks(int n, logic bus);
    repeat (n)
    begin
      @(negedge clock);
      rc_osc_tick = !bus;
      bus_x2_tick = bus;
      #5 n_req += (wakeup_request === 1'b1);
    end
    @(negedge clock);
    {rc_osc_tick, bus_x2_tick} = 2'b00;
    @(negedge clock);
  endtask : ticks
  task stop_to(logic s);
    @(negedge clock);
    stop_mode = s;
    @(negedge clock);
  endtask : stop_to
  task final_report;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    #(40 * 30000);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (20) @(negedge clock);
    rst_n = 1;
    chk("port_a", 8'h00, port_a_read);
    chk("ack_read", 8'h00, {7'h0, ack_read});
    chk("flag", 8'h00, {7'h0, keyboard_pending_flag});
    wakeup_irq_enable = 1;
    ticks(600, 0);
    chk("latch run", 8'h00, {7'h0, wakeup_latch});
    wait_mode = 1;
    stop_to(1);
    ticks(600, 0);
    chk("latch wait", 8'h00, {7'h0, wakeup_latch});
    {wait_mode, wakeup_irq_enable} = 2'b00;
    ticks(600, 0);
    chk("latch off", 8'h00, {7'h0, wakeup_latch});
    $display("test idle modes done");
    wakeup_irq_enable = 1;
    stop_to(0);
    stop_to(1);
    ticks(300, 0);
    stop_to(0);
    stop_to(1);
    ticks(511, 0);
    chk("no early wake", 8'h00, port_a_read);
    clk_en = 0;
    ticks(1, 0);
    clk_en = 1;
    chk("frozen", 8'h00, port_a_read);
    ticks(1, 0);
    chk("short wake", 8'h40, port_a_read);
    {keyboard_irq_mask, wakeup_irq_enable} = 2'b00;
    @(negedge clock);
    chk("read no enable", 8'h40, port_a_read);
    chk("irq no enable", 8'h00, {7'h0, irq_to_cpu});
    wakeup_irq_enable = 1;
    @(negedge clock);
    chk("irq enabled", 8'h01, {7'h0, irq_to_cpu});
    serve = 1;
    repeat (8) @(negedge clock);
    chk("acked", 8'h00, {6'h0, wakeup_latch, keyboard_pending_flag});
    $display("test short period done");
    clock_keep_in_stop = 1;
    ticks(512, 0);
    chk("rc ignored", 8'h00, {7'h0, wakeup_latch});
    ticks(512, 1);
    chk("bus wake", 8'h01, {7'h0, wakeup_latch});
    repeat (8) @(negedge clock);
    {serve, period_select} = 2'b00;
    ticks(16383, 1);
    chk("long early", 8'h00, {7'h0, wakeup_latch});
    ticks(1, 1);
    chk("long wake", 8'h01, {7'h0, wakeup_latch});
    chk("requests", 8'h03, n_req[7:0]);
    rst_n = 0;
    stop_to(0);
    rst_n = 1;
    chk("reset clears", 8'h00, port_a_read);
    keyboard_request = 1;
    @(negedge clock);
    keyboard_request = 0;
    @(negedge clock);
    chk("key flag", 8'h01, {7'h0, keyboard_pending_flag});
    $display("test clock source and long period done");
    final_report;
  end
endmodule : periodic_wakeup_unit_tb
